// ===== hw/qdac_core.sv
// quad converter code update logic with serial link and register bus
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Overview of operation
// [RL1] channels 0,1 group A; 2,3 group B
// [RL2] each channel corrected by its own trims
// [RL3] gain step 1 LSB unipolar, 1/4 LSB bipolar (at full scale), zero step 1/8
// [RL4] gain trim signed, -128 to +127
// [RL5] zero trim signed, -256 to +255
// [RL6] both trims reset to zero
// [RL7] bipolar group: code is twos complement
// [RL8] unipolar group: code is straight binary
// [RL9] reads return the written format
// [RL10] polarity pin high unipolar, low bipolar
// [RL11] host sets gain bit to match wiring
// [RL12] gain bits reset to one
// [RL13] input register written after valid frame
// [RL14] load moves only written channels
// [RL15] strobe low during write: latch too
// [RL16] strobe high during write: input only
// [RL17] strobe fall or load bit loads
// [RL18] calibrated code from code, zero, gain
module qdac_core
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_clk,
    input wire logic frame_sel_n,
    input wire logic link_data,
    input wire logic load_strobe_n,
    input wire logic group_a_polarity_select,
    input wire logic group_b_polarity_select,
    output logic [3:0][15:0] dac_code,
    output logic [3:0] gain_four,
    output logic [1:0] group_unipolar
);
    // =====================================================================
    // functions
    function automatic logic [7:0] gray_to_bin(input logic [7:0] g);
        logic [7:0] b;
        b[7] = g[7];
        for (int i = 6; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray_to_bin

    function automatic logic [15:0] calibrate(input logic [15:0] code,
                                              input qdac_pkg::qdac_trim_s trim,
                                              input logic uni);
        logic signed [20:0] base;
        logic signed [28:0] prod;
        logic signed [28:0] sum;
        logic signed [25:0] res;
        base = '0;
        prod = '0;
        sum = '0;
        res = '0;
        if (uni)
        begin
            base = $signed({5'h00, code}); // [RL8]
        end
        else
        begin
            base = $signed({{5{code[15]}}, code}); // [RL7]
        end
        base = (base <<< qdac_pkg::QDAC_ZERO_FRAC) + 21'(trim.zero); // [RL3]
        prod = 29'(base) * 29'(trim.gain);
        if (uni)
        begin
            sum = 29'(base) + (prod >>> qdac_pkg::QDAC_UNI_SHIFT); // [RL18]
        end
        else
        begin
            sum = 29'(base) + (prod >>> qdac_pkg::QDAC_BIP_SHIFT); // [RL18]
        end
        res = 26'(sum >>> qdac_pkg::QDAC_ZERO_FRAC);
        if (uni)
        begin
            if (res < 0)
            begin
                return qdac_pkg::QDAC_CODE_RESET;
            end
            else if (res > $signed({10'h000, qdac_pkg::QDAC_UNI_MAX}))
            begin
                return qdac_pkg::QDAC_UNI_MAX;
            end
        end
        else
        begin
            if (res > $signed({10'h000, qdac_pkg::QDAC_BIP_MAX}))
            begin
                return qdac_pkg::QDAC_BIP_MAX;
            end
            else if (res < $signed({{10{1'b1}}, qdac_pkg::QDAC_BIP_MIN}))
            begin
                return qdac_pkg::QDAC_BIP_MIN;
            end
        end
        return res[15:0];
    endfunction : calibrate

    // =====================================================================
    // link domain: shift register and gray edge counter
    qdac_pkg::qdac_frame_s link_shift;
    logic [7:0] link_cnt_bin;
    logic [7:0] link_cnt_gray;

    always_ff @(negedge link_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_shift <= '0;
            link_cnt_bin <= 8'h00;
            link_cnt_gray <= 8'h00;
        end
        else if (!frame_sel_n)
        begin
            link_shift <= {link_shift[22:0], link_data};
            link_cnt_bin <= link_cnt_bin + 8'h01;
            link_cnt_gray <= (link_cnt_bin + 8'h01) ^ ((link_cnt_bin + 8'h01) >> 1);
        end
    end

    // =====================================================================
    // pin synchronisers: change accepted once stages two and three agree
    logic [3:0] pin_raw;
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_q;
    logic sel_q;
    logic strobe_q;
    logic strobe_prev;
    logic sel_prev;

    assign pin_raw = {group_b_polarity_select, group_a_polarity_select,
                      load_strobe_n, frame_sel_n};

    generate
        for (genvar p = 0; p < 4; p++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_s1[p] <= 1'b1;
                    pin_s2[p] <= 1'b1;
                    pin_s3[p] <= 1'b1;
                    pin_q[p] <= 1'b1;
                end
                else if (pce)
                begin
                    pin_s1[p] <= pin_raw[p];
                    pin_s2[p] <= pin_s1[p];
                    pin_s3[p] <= pin_s2[p];
                    if (pin_s2[p] == pin_s3[p])
                    begin
                        pin_q[p] <= pin_s3[p];
                    end
                end
            end
        end
    endgenerate

    assign sel_q = pin_q[0];
    assign strobe_q = pin_q[1];

    // =====================================================================
    // frame completion in the bus domain
    logic [7:0] cnt_s1;
    logic [7:0] cnt_s2;
    logic [7:0] last_end;
    logic [7:0] frame_edges;
    logic ser_pend;
    logic ser_go;
    logic apb_do;
    qdac_pkg::qdac_frame_s ser_word;

    assign frame_edges = gray_to_bin(cnt_s2) - last_end;
    assign apb_do = pce && psel && penable && pready;
    assign ser_go = ser_pend && !apb_do && pce;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_s1 <= 8'h00;
            cnt_s2 <= 8'h00;
            last_end <= 8'h00;
            sel_prev <= 1'b1;
            strobe_prev <= 1'b1;
            ser_pend <= 1'b0;
            ser_word <= '0;
        end
        else if (pce)
        begin
            cnt_s1 <= link_cnt_gray;
            cnt_s2 <= cnt_s1;
            sel_prev <= sel_q;
            strobe_prev <= strobe_q;
            if (sel_q && !sel_prev)
            begin
                last_end <= gray_to_bin(cnt_s2);
                if (frame_edges >= qdac_pkg::QDAC_FRAME_MIN)
                begin
                    ser_word <= link_shift; // [RL13]
                    ser_pend <= 1'b1;
                end
            end
            else if (ser_go)
            begin
                ser_pend <= 1'b0;
            end
        end
    end

    // =====================================================================
    // write source selection
    logic wr_go;
    logic [3:0] wr_idx;
    logic [15:0] wr_data;
    logic ld_evt;

    always_comb
    begin
        wr_go = 1'b0;
        wr_idx = 4'h0;
        wr_data = 16'h0000;
        if (apb_do && pwrite && paddr < qdac_pkg::QDAC_OFS_STATUS && paddr[1:0] == 2'h0)
        begin
            wr_go = 1'b1;
            wr_idx = paddr[5:2];
            wr_data = pwdata[15:0];
        end
        else if (ser_go && !ser_word.rw)
        begin
            wr_go = 1'b1; // [RL13]
            wr_idx = ser_word.addr;
            wr_data = ser_word.data;
        end
    end

    assign ld_evt = (pce && strobe_prev && !strobe_q)
                    || (wr_go && wr_idx == qdac_pkg::QDAC_IDX_CMD
                        && wr_data[qdac_pkg::QDAC_CMD_LOAD_BIT]); // [RL17]

    // =====================================================================
    // command register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gain_four <= qdac_pkg::QDAC_GAIN_RESET; // [RL12]
        end
        else if (pce && wr_go && wr_idx == qdac_pkg::QDAC_IDX_CMD)
        begin
            gain_four <= wr_data[qdac_pkg::QDAC_CMD_GAIN_LSB +: 4]; // [RL11]
        end
    end

    // =====================================================================
    // per channel input register, output latch, trims, calibrated code
    logic [15:0] in_reg [4];
    logic [15:0] latch_reg [4];
    qdac_pkg::qdac_trim_s trim [4];
    logic [3:0] pend;
    logic [3:0] chan_uni;

    generate
        for (genvar c = 0; c < 4; c++)
        begin : g_chan
            assign chan_uni[c] = (c <= qdac_pkg::QDAC_GROUP_A_LAST) ? pin_q[2] : pin_q[3]; // [RL1]

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    in_reg[c] <= qdac_pkg::QDAC_CODE_RESET;
                    latch_reg[c] <= qdac_pkg::QDAC_CODE_RESET;
                    pend[c] <= 1'b0;
                end
                else if (pce)
                begin
                    if (wr_go && wr_idx == qdac_pkg::QDAC_IDX_INPUT + 4'(c))
                    begin
                        in_reg[c] <= wr_data; // [RL13]
                        if (!strobe_q)
                        begin
                            latch_reg[c] <= wr_data; // [RL15]
                            pend[c] <= 1'b0;
                        end
                        else
                        begin
                            if (ld_evt && pend[c])
                            begin
                                latch_reg[c] <= in_reg[c];
                            end
                            pend[c] <= 1'b1; // [RL16]
                        end
                    end
                    else if (ld_evt && pend[c])
                    begin
                        latch_reg[c] <= in_reg[c]; // [RL14]
                        pend[c] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    trim[c] <= qdac_pkg::QDAC_TRIM_RESET; // [RL6]
                end
                else if (pce && wr_go)
                begin
                    if (wr_idx == qdac_pkg::QDAC_IDX_ZERO + 4'(c))
                    begin
                        trim[c].zero <= wr_data[qdac_pkg::QDAC_ZERO_TRIM_W-1:0]; // [RL5]
                    end
                    else if (wr_idx == qdac_pkg::QDAC_IDX_GAIN + 4'(c))
                    begin
                        trim[c].gain <= wr_data[qdac_pkg::QDAC_GAIN_TRIM_W-1:0]; // [RL4]
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    dac_code[c] <= qdac_pkg::QDAC_CODE_RESET;
                end
                else if (pce)
                begin
                    dac_code[c] <= calibrate(latch_reg[c], trim[c], chan_uni[c]); // [RL2]
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            group_unipolar <= 2'h0;
        end
        else if (pce)
        begin
            group_unipolar <= pin_q[3:2]; // [RL10]
        end
    end

    // =====================================================================
    // bus read decode
    logic [31:0] rd_value;
    logic rd_ok;
    logic [1:0] rd_ch;

    assign rd_ch = paddr[3:2];

    always_comb
    begin
        rd_value = 32'h0000_0000;
        rd_ok = (paddr[1:0] == 2'h0) && (paddr < qdac_pkg::QDAC_OFS_END);
        if (paddr[7:4] == 4'h0 && paddr[3:2] != 2'h0)
        begin
            rd_ok = 1'b0;
        end
        else if (paddr[7:2] == 6'(qdac_pkg::QDAC_IDX_CMD))
        begin
            rd_value[qdac_pkg::QDAC_CMD_GAIN_LSB +: 4] = gain_four; // [RL9]
        end
        else if (paddr[7:4] == 4'h1)
        begin
            rd_value[15:0] = in_reg[rd_ch]; // [RL9]
        end
        else if (paddr[7:4] == 4'h2)
        begin
            rd_value[15:0] = 16'(trim[rd_ch].zero); // [RL9]
        end
        else if (paddr[7:4] == 4'h3)
        begin
            rd_value[15:0] = 16'(trim[rd_ch].gain); // [RL9]
        end
        else if (paddr == qdac_pkg::QDAC_OFS_STATUS)
        begin
            rd_value[7:0] = {2'h0, pin_q[3:2], pend};
        end
        else if (paddr[7:4] == qdac_pkg::QDAC_OFS_LATCH[7:4])
        begin
            rd_value[15:0] = latch_reg[rd_ch];
        end
        else if (paddr[7:4] == qdac_pkg::QDAC_OFS_CAL[7:4])
        begin
            rd_value[15:0] = dac_code[rd_ch];
        end
        else
        begin
            rd_ok = 1'b0;
        end
        if (pwrite && paddr >= qdac_pkg::QDAC_OFS_STATUS)
        begin
            rd_ok = 1'b0;
        end
    end

    // =====================================================================
    // bus handshake: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (pce)
        begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready)
            begin
                pslverr <= !rd_ok;
                prdata <= (pwrite || !rd_ok) ? 32'h0000_0000 : rd_value;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule : qdac_core
`default_nettype wire

// ===== hw/qdac_pkg.sv
// constants and carrier types for the quad converter code update logic
package qdac_pkg;
    // =====================================================================
    // channel and group layout
    localparam int unsigned QDAC_CHANNELS = 4;
    localparam int unsigned QDAC_CODE_W = 16;
    localparam int unsigned QDAC_GROUP_A_LAST = 1;
    // =====================================================================
    // serial frame layout
    localparam int unsigned QDAC_FRAME_BITS = 24;
    localparam logic [7:0] QDAC_FRAME_MIN = 8'h18;
    localparam int unsigned QDAC_EDGE_CNT_W = 8;
    // =====================================================================
    // register indices, shared by the serial port and the bus
    localparam logic [3:0] QDAC_IDX_CMD = 4'h0;
    localparam logic [3:0] QDAC_IDX_INPUT = 4'h4;
    localparam logic [3:0] QDAC_IDX_ZERO = 4'h8;
    localparam logic [3:0] QDAC_IDX_GAIN = 4'hC;
    // bus byte addresses of the read-only views
    localparam logic [7:0] QDAC_OFS_STATUS = 8'h40;
    localparam logic [7:0] QDAC_OFS_LATCH = 8'h50;
    localparam logic [7:0] QDAC_OFS_CAL = 8'h60;
    localparam logic [7:0] QDAC_OFS_END = 8'h70;
    // =====================================================================
    // command register fields and reset values
    localparam int unsigned QDAC_CMD_GAIN_LSB = 0;
    localparam int unsigned QDAC_CMD_LOAD_BIT = 8;
    localparam logic [3:0] QDAC_GAIN_RESET = 4'hF;
    localparam logic [15:0] QDAC_CODE_RESET = 16'h0000;
    // =====================================================================
    // trim ranges
    localparam int unsigned QDAC_GAIN_TRIM_W = 8;
    localparam int unsigned QDAC_ZERO_TRIM_W = 9;
    localparam int unsigned QDAC_ZERO_FRAC = 3;
    localparam int unsigned QDAC_UNI_SHIFT = 16;
    localparam int unsigned QDAC_BIP_SHIFT = 17;
    localparam logic [15:0] QDAC_UNI_MAX = 16'hFFFF;
    localparam logic [15:0] QDAC_BIP_MAX = 16'h7FFF;
    localparam logic [15:0] QDAC_BIP_MIN = 16'h8000;
    // =====================================================================
    // carrier types
    typedef struct packed {
        logic signed [QDAC_GAIN_TRIM_W-1:0] gain;
        logic signed [QDAC_ZERO_TRIM_W-1:0] zero;
    } qdac_trim_s;

    typedef struct packed {
        logic rw;
        logic [3:0] addr;
        logic [2:0] rsvd;
        logic [15:0] data;
    } qdac_frame_s;

    localparam qdac_trim_s QDAC_TRIM_RESET = '0;
endpackage : qdac_pkg

// ===== verif/qdac_core_sva.sv
// assertions on the ports of the quad converter code update logic
`timescale 1ns/10ps
`default_nettype none
module qdac_core_sva
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic frame_sel_n,
    input wire logic group_a_polarity_select,
    input wire logic group_b_polarity_select,
    input wire logic [3:0] gain_four,
    input wire logic [1:0] group_unipolar
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // =====================================================================
    // reset and polarity
    a_reset_gain_ones: assert property ($rose(presetn) |-> gain_four == 4'hF)
        else $error("gain bits not all set after reset");
    a_pol_a_follow: assert property ($stable(group_a_polarity_select) [*8] |->
        group_unipolar[0] == group_a_polarity_select)
        else $error("group a polarity not following its pin");
    a_pol_b_follow: assert property ($stable(group_b_polarity_select) [*8] |->
        group_unipolar[1] == group_b_polarity_select)
        else $error("group b polarity not following its pin");
    // =====================================================================
    // register bus
    a_bus_answer: assert property (psel && penable && !pready |=> pready)
        else $error("bus access not answered after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_refuse_high: assert property (psel && penable && !pready && paddr >= 8'h70 |=> pslverr)
        else $error("access above the map not refused");
    a_cmd_readback: assert property (psel && penable && !pready && !pwrite && paddr == 8'h00
        |=> prdata[3:0] == gain_four && !prdata[8])
        else $error("command read differs from gain bits");
    a_status_pol: assert property (psel && penable && !pready && !pwrite && paddr == 8'h40
        |=> prdata[5:4] == group_unipolar)
        else $error("status polarity differs from groups");
    a_gain_cause: assert property ($changed(gain_four) |->
        ($past(pready) && $past(pwrite) && $past(paddr) == 8'h00) || $past(frame_sel_n, 4))
        else $error("gain bits changed without a write");
endmodule : qdac_core_sva

bind qdac_core qdac_core_sva qdac_core_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_sel_n(frame_sel_n),
    .group_a_polarity_select(group_a_polarity_select),
    .group_b_polarity_select(group_b_polarity_select), .gain_four(gain_four),
    .group_unipolar(group_unipolar));
`default_nettype wire

// ===== verif/qdac_host_model.sv
// serial host model driving the link side of the converter
`timescale 1ns/10ps
`default_nettype none
module qdac_host_model
(
    output logic link_clk,
    output logic frame_sel_n,
    output logic link_data
);
    // idle: clock parked high so the first edge of a frame falls
    initial
    begin
        link_clk = 1'b1;
        frame_sel_n = 1'b1;
        link_data = 1'b0;
    end
    // =====================================================================
    // one 24-bit frame, most significant bit first, 15 ns clock
    task automatic send(input logic [23:0] w);
        frame_sel_n = 1'b0;
        #20;
        for (int i = 23; i >= 0; i--)
        begin
            link_data = w[i];
            #7.5 link_clk = 1'b0;
            #7.5 link_clk = 1'b1;
        end
        #15 frame_sel_n = 1'b1;
        link_data = ~link_data;
        #300;
    endtask : send
endmodule : qdac_host_model
`default_nettype wire

// ===== verif/tb.sv
// testbench for the quad converter code update logic
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic pclk, presetn, pce, psel, penable, pwrite, load_strobe_n, pol_a, pol_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, link_clk, frame_sel_n, link_data;
    logic [3:0][15:0] dac_code;
    logic [3:0] gain_four;
    logic [1:0] group_unipolar;
    logic [8:0] bad [3] = '{9'h070, 9'h140, 9'h004};
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    // =====================================================================
    // clock, design and host
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    qdac_core qdac_core_inst (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .frame_sel_n(frame_sel_n),
        .link_data(link_data), .load_strobe_n(load_strobe_n), .group_a_polarity_select(pol_a),
        .group_b_polarity_select(pol_b), .dac_code(dac_code), .gain_four(gain_four),
        .group_unipolar(group_unipolar));
    qdac_host_model qdac_host_model_inst (.link_clk(link_clk), .frame_sel_n(frame_sel_n),
        .link_data(link_data));
    // =====================================================================
    // helpers
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        apb(1'b0, a, 32'h0);
        check({16'h0, rd[15:0]}, {16'h0, exp});
    endtask : rchk
    task automatic dchk(input int i, input logic [15:0] exp);
        check({16'h0, dac_code[i]}, {16'h0, exp});
    endtask : dchk
    task automatic ser(input logic [3:0] idx, input logic [15:0] d);
        qdac_host_model_inst.send({1'b0, idx, 3'h0, d});
        repeat (10) @(posedge pclk);
    endtask : ser
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_cyc
    // =====================================================================
    // main sequence
    initial
    begin
        presetn = 1'b0;
        pce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        load_strobe_n = 1'b1;
        pol_a = 1'b1;
        pol_b = 1'b1;
        wait_cyc(3);
        presetn <= 1'b1;
        wait_cyc(8);
        rchk(8'h00, 16'h000F);
        for (int i = 0; i < 4; i++)
        begin
            dchk(i, 16'h0000);
            rchk(8'(8'h20 + 4 * i), 16'h0000);
            rchk(8'(8'h30 + 4 * i), 16'h0000);
        end
        $display("test reset values done");
        apb(1'b1, 8'h20, 32'h0000_0100);
        rchk(8'h20, 16'hFF00);
        apb(1'b1, 8'h20, 32'h0000_00FF);
        rchk(8'h20, 16'h00FF);
        apb(1'b1, 8'h30, 32'h0000_0080);
        rchk(8'h30, 16'hFF80);
        apb(1'b1, 8'h30, 32'h0000_007F);
        rchk(8'h30, 16'h007F);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b1, 8'h30, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            apb(bad[i][8], bad[i][7:0], 32'h0);
            check({31'h0, err}, 32'h1);
        end
        $display("test trims and refusals done");
        ser(4'h4, 16'h1234);
        dchk(0, 16'h0000);
        rchk(8'h40, 16'h0031);
        load_strobe_n <= 1'b0;
        wait_cyc(8);
        dchk(0, 16'h1234);
        dchk(1, 16'h0000);
        rchk(8'h50, 16'h1234);
        ser(4'h5, 16'hABCD);
        dchk(1, 16'hABCD);
        dchk(0, 16'h1234);
        load_strobe_n <= 1'b1;
        ser(4'h6, 16'h5555);
        apb(1'b1, 8'h1C, 32'h0000_7FFF);
        wait_cyc(3);
        dchk(2, 16'h0000);
        apb(1'b1, 8'h00, 32'h0000_0105);
        wait_cyc(3);
        check({28'h0, gain_four}, 32'h0000_0005);
        dchk(2, 16'h5555);
        dchk(3, 16'h7FFF);
        rchk(8'h00, 16'h0005);
        $display("test load paths done");
        apb(1'b1, 8'h20, 32'h0000_0008);
        apb(1'b1, 8'h34, 32'h0000_007F);
        apb(1'b1, 8'h2C, 32'h0000_00FF);
        wait_cyc(3);
        dchk(0, 16'h1235);
        dchk(1, 16'hAC22);
        dchk(3, 16'h801E);
        dchk(2, 16'h5555);
        pol_b <= 1'b0;
        wait_cyc(10);
        dchk(3, 16'h7FFF);
        dchk(0, 16'h1235);
        rchk(8'h40, 16'h0010);
        apb(1'b1, 8'h2C, 32'h0000_0100);
        apb(1'b1, 8'h1C, 32'h0000_8000);
        apb(1'b1, 8'h00, 32'h0000_0105);
        wait_cyc(3);
        dchk(3, 16'h8000);
        pol_b <= 1'b1;
        wait_cyc(10);
        dchk(3, 16'h7FE0);
        $display("test calibration done");
        apb(1'b1, 8'h18, 32'h0000_1111);
        pce <= 1'b0;
        load_strobe_n <= 1'b0;
        wait_cyc(10);
        dchk(2, 16'h5555);
        pce <= 1'b1;
        wait_cyc(8);
        dchk(2, 16'h1111);
        load_strobe_n <= 1'b1;
        wait_cyc(6);
        $display("test clock enable done");
        presetn <= 1'b0;
        wait_cyc(3);
        presetn <= 1'b1;
        wait_cyc(8);
        check({28'h0, gain_four}, 32'h0000_000F);
        dchk(1, 16'h0000);
        rchk(8'h2C, 16'h0000);
        $display("test second reset done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
